// [hdl/octal_enable_pkg.sv]
// Purpose: Shared constants for the octal-mode enable descriptor, its device end and its host end.
// Assumes: One clock, synchronous active-high reset, 32-bit descriptor word.
package octal_enable_pkg;

  // Descriptor field positions.
  localparam int AVAIL_BIT  = 31;
  localparam int POL_BIT    = 30;
  localparam int RSVD_BIT   = 29;
  localparam int ACCESS_BIT = 28;
  localparam int APOS_BIT   = 27;
  localparam int BPOS_HI    = 26;
  localparam int BPOS_LO    = 24;
  localparam int LADDR_HI   = 23;
  localparam int LADDR_LO   = 16;
  localparam int FLAG_8D    = 23;
  localparam int FLAG_8S    = 22;
  localparam int FLAG_4D    = 21;
  localparam int FLAG_4S    = 20;
  localparam int DUMMY_HI   = 19;
  localparam int DUMMY_LO   = 16;
  localparam int RDOP_HI    = 15;
  localparam int RDOP_LO    = 8;
  localparam int WROP_HI    = 7;
  localparam int WROP_LO    = 0;

  // Host register offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DESC   = 8'h08;
  localparam logic [7:0] OFS_REGVAL = 8'h0C;

  // Host control and status bit positions.
  localparam int CTRL_FETCH = 0;
  localparam int CTRL_SET   = 1;
  localparam int CTRL_WANT  = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_MODE_HI = 6;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_ERR   = 2;
  localparam int STAT_DESC  = 3;
  localparam int STAT_OCTAL = 4;

  // Reset values and timing.
  localparam logic [31:0] DESC_RST    = 32'h0000_0000;
  localparam logic [7:0]  REGVAL_RST  = 8'h00;
  localparam logic [3:0]  RSP_TIMEOUT = 4'hF;

  // Transfer modes a command may be sent in.
  typedef enum logic [2:0] {
    MODE_1S1S1S = 3'h0,
    MODE_8D8D8D = 3'h1,
    MODE_8S8S8S = 3'h2,
    MODE_4S4D4D = 3'h3,
    MODE_4S4S4S = 3'h4
  } mode_e;

endpackage : octal_enable_pkg

// [hdl/octal_enable_if.sv]
// Purpose: Link between the host controller and the flash end serving the descriptor.
// Assumes: Both ends share clk_i; every signal changes right after a rising edge.
// Notes:   A request is one cycle; the answer is one cycle, on the next edge.
`timescale 1ns/100ps
`default_nettype none
interface octal_enable_if;
  import octal_enable_pkg::*;
  logic        desc_req;
  logic        desc_valid;
  logic [31:0] desc_word;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_opcode;
  logic [31:0] cmd_addr;
  mode_e       cmd_mode;
  logic [3:0]  cmd_dummy;
  logic [7:0]  cmd_wdata;
  logic        rsp_valid;
  logic        rsp_ok;
  logic [7:0]  rsp_rdata;

  modport host (output desc_req, cmd_valid, cmd_write, cmd_opcode, cmd_addr, cmd_mode, cmd_dummy, cmd_wdata,
                input desc_valid, desc_word, rsp_valid, rsp_ok, rsp_rdata);
  modport dev  (input desc_req, cmd_valid, cmd_write, cmd_opcode, cmd_addr, cmd_mode, cmd_dummy, cmd_wdata,
                output desc_valid, desc_word, rsp_valid, rsp_ok, rsp_rdata);
endinterface : octal_enable_if
`default_nettype wire

// [hdl/octal_enable_dev.sv]
// Purpose: Flash end: serves the descriptor word and the register holding the volatile enable bit.
// Assumes: Descriptor content is set by parameters; host keeps its own obligations.
// Notes:   Commands that do not match the advertised access form are answered with rsp_ok low.
`timescale 1ns/100ps
`default_nettype none
module octal_enable_dev
  import octal_enable_pkg::*;
#(
  parameter logic       AVAIL      = 1'b1,
  parameter logic       POL        = 1'b0,
  parameter logic       ACCESS     = 1'b0,
  parameter logic       APOS       = 1'b0,
  parameter int         ADDR_BYTES = 3,
  parameter logic [2:0] BIT_POS    = 3'h3,
  parameter logic [7:0] LOCAL_ADDR = 8'h02,
  parameter logic [3:0] MODE_FLAGS = 4'hA,
  parameter logic [3:0] DUMMY      = 4'h8,
  parameter logic [7:0] RD_OP      = 8'h05,
  parameter logic [7:0] WR_OP      = 8'h01
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Link to the host.
  octal_enable_if.dev     lnk,
  // Device state seen by the user.
  output logic [7:0]      flash_reg_o,
  output logic            octal_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor word. Byte-one placement is dropped for 8-bit addressing.
  localparam logic APOS_EFF = (ADDR_BYTES == 1) ? 1'b0 : APOS;
  localparam logic [7:0] LOW_FIELD = ACCESS ? LOCAL_ADDR : {MODE_FLAGS, DUMMY};
  localparam logic [31:0] DESC = {AVAIL, POL, 1'b0, ACCESS, APOS_EFF, BIT_POS, LOW_FIELD, RD_OP, WR_OP};

  typedef struct packed {
    logic        desc_valid;
    logic        rsp_valid;
    logic        rsp_ok;
    logic [7:0]  rsp_rdata;
    logic [7:0]  flash_reg;
    logic        octal_mode;
  } dev_s;

  dev_s s_r;
  dev_s s_nxt;
  logic op_ok;
  logic fmt_ok;
  logic [7:0] addr_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Command check and register update; answers land one cycle after the request.
  always_comb begin
    s_nxt            = s_r;
    s_nxt.desc_valid = lnk.desc_req;
    s_nxt.rsp_valid  = lnk.cmd_valid;
    s_nxt.rsp_ok     = 1'b0;
    s_nxt.rsp_rdata  = 8'h00;
    // A zero opcode means that direction is not offered at all.
    op_ok = lnk.cmd_write ? (WR_OP != 8'h00 && lnk.cmd_opcode == WR_OP)
                          : (RD_OP != 8'h00 && lnk.cmd_opcode == RD_OP);
    addr_byte = APOS_EFF ? lnk.cmd_addr[15:8] : lnk.cmd_addr[7:0];
    if (ACCESS) begin
      fmt_ok = (addr_byte == LOCAL_ADDR);
    end else begin
      unique case (lnk.cmd_mode)
        MODE_1S1S1S: fmt_ok = (lnk.cmd_dummy == 4'h0);
        MODE_8D8D8D: fmt_ok = MODE_FLAGS[3] && lnk.cmd_dummy == DUMMY;
        MODE_8S8S8S: fmt_ok = MODE_FLAGS[2] && lnk.cmd_dummy == DUMMY;
        MODE_4S4D4D: fmt_ok = MODE_FLAGS[1] && lnk.cmd_dummy == DUMMY;
        MODE_4S4S4S: fmt_ok = MODE_FLAGS[0] && lnk.cmd_dummy == DUMMY;
        default:     fmt_ok = 1'b0;
      endcase
    end
    if (lnk.cmd_valid && AVAIL && op_ok && fmt_ok) begin
      s_nxt.rsp_ok = 1'b1;
      if (lnk.cmd_write) begin
        s_nxt.flash_reg = lnk.cmd_wdata;
      end else begin
        s_nxt.rsp_rdata = s_r.flash_reg;
      end
    end
    s_nxt.octal_mode = AVAIL && (s_nxt.flash_reg[BIT_POS] ^ POL);
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the descriptor word is a constant and therefore always stable.
  assign lnk.desc_valid = s_r.desc_valid;
  assign lnk.desc_word  = DESC;
  assign lnk.rsp_valid  = s_r.rsp_valid;
  assign lnk.rsp_ok     = s_r.rsp_ok;
  assign lnk.rsp_rdata  = s_r.rsp_rdata;
  assign flash_reg_o    = s_r.flash_reg;
  assign octal_mode_o   = s_r.octal_mode;

endmodule : octal_enable_dev
`default_nettype wire

// [hdl/octal_enable_host.sv]
// Purpose: Host controller: fetches the descriptor and changes the volatile octal enable bit.
// Assumes: Software drives a plain register port; the flash end answers within RSP_TIMEOUT cycles.
// Notes:   Starts are ignored while busy; completion and failure are sticky until the next start.
`timescale 1ns/100ps
`default_nettype none
module octal_enable_host
  import octal_enable_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Software register port.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // Link to the flash end.
  octal_enable_if.host     lnk
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_READ  = 4'b0100,
    ST_WRITE = 4'b1000
  } state_e;

  typedef struct packed {
    state_e      state;
    logic [31:0] desc;
    logic        desc_ok;
    logic        busy;
    logic        done;
    logic        err;
    logic        want;
    logic        chain;
    mode_e       mode;
    logic [7:0]  regval;
    logic [3:0]  timer;
    logic        desc_req;
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_opcode;
    logic [31:0] cmd_addr;
    mode_e       cmd_mode;
    logic [3:0]  cmd_dummy;
    logic [7:0]  cmd_wdata;
    logic [31:0] rdata;
  } host_s;

  host_s s_r;
  host_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor fields seen through the fetched word.
  logic       f_avail;
  logic       f_pol;
  logic       f_access;
  logic       f_apos;
  logic [2:0] f_bpos;
  logic [7:0] f_laddr;
  logic [3:0] f_dummy;
  logic [7:0] f_rdop;
  logic [7:0] f_wrop;
  logic       f_flag;
  logic       set_bad;
  logic [7:0] new_val;
  logic [31:0] tgt_addr;

  // The reserved bit is never decoded, so a later meaning cannot disturb us.
  assign f_avail  = s_r.desc[AVAIL_BIT];
  assign f_pol    = s_r.desc[POL_BIT];
  assign f_access = s_r.desc[ACCESS_BIT];
  assign f_apos   = s_r.desc[APOS_BIT];
  assign f_bpos   = s_r.desc[BPOS_HI:BPOS_LO];
  assign f_laddr  = s_r.desc[LADDR_HI:LADDR_LO];
  assign f_dummy  = s_r.desc[DUMMY_HI:DUMMY_LO];
  assign f_rdop   = s_r.desc[RDOP_HI:RDOP_LO];
  assign f_wrop   = s_r.desc[WROP_HI:WROP_LO];

  // Flag for the mode software asked for; single-line needs no flag.
  always_comb begin
    unique case (s_r.mode)
      MODE_1S1S1S: f_flag = 1'b1;
      MODE_8D8D8D: f_flag = s_r.desc[FLAG_8D];
      MODE_8S8S8S: f_flag = s_r.desc[FLAG_8S];
      MODE_4S4D4D: f_flag = s_r.desc[FLAG_4D];
      MODE_4S4S4S: f_flag = s_r.desc[FLAG_4S];
      default:     f_flag = 1'b0;
    endcase
  end

  // A cleared flag is not taken as proof the mode works with some other count, so it is refused.
  assign set_bad = !f_avail || f_wrop == 8'h00 || f_rdop == 8'h00 ||
                   (!f_access && !f_flag);

  // Local address goes in byte zero or byte one of the address phase.
  assign tgt_addr = !f_access ? 32'h0000_0000 :
                    (f_apos ? {16'h0000, f_laddr, 8'h00} : {24'h00_0000, f_laddr});

  // Only the located bit changes; its stored level follows the polarity.
  always_comb begin
    new_val         = s_r.regval;
    new_val[f_bpos] = s_r.want ^ f_pol;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port, sequencer and link requests.
  always_comb begin
    s_nxt           = s_r;
    s_nxt.desc_req  = 1'b0;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.rdata     = 32'h0000_0000;
    // Read data stands in the cycle after the strobe only.
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_CTRL:   s_nxt.rdata = {25'h0, s_r.mode, 1'b0, s_r.want, 2'b00};
        OFS_STATUS: s_nxt.rdata = {27'h0, s_r.desc_ok && (s_r.regval[f_bpos] ^ f_pol),
                                   s_r.desc_ok, s_r.err, s_r.done, s_r.busy};
        OFS_DESC:   s_nxt.rdata = s_r.desc;
        OFS_REGVAL: s_nxt.rdata = {24'h00_0000, s_r.regval};
        default:    s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    unique case (s_r.state)
      ST_IDLE: begin
        if (reg_wr_i && reg_addr_i == OFS_CTRL &&
            (reg_wdata_i[CTRL_FETCH] || reg_wdata_i[CTRL_SET])) begin
          s_nxt.want  = reg_wdata_i[CTRL_WANT];
          s_nxt.mode  = mode_e'(reg_wdata_i[CTRL_MODE_HI:CTRL_MODE_LO]);
          s_nxt.chain = reg_wdata_i[CTRL_SET];
          s_nxt.done  = 1'b0;
          s_nxt.err   = 1'b0;
          s_nxt.busy  = 1'b1;
          s_nxt.timer = RSP_TIMEOUT;
          if (reg_wdata_i[CTRL_FETCH] || !s_r.desc_ok) begin
            s_nxt.desc_req = 1'b1;
            s_nxt.state    = ST_FETCH;
          end else begin
            s_nxt.state = ST_READ;
          end
        end
      end
      ST_FETCH: begin
        s_nxt.timer = s_r.timer - 4'h1;
        if (lnk.desc_valid) begin
          s_nxt.desc    = lnk.desc_word;
          s_nxt.desc_ok = 1'b1;
          s_nxt.timer   = RSP_TIMEOUT;
          if (s_r.chain) begin
            s_nxt.state = ST_READ;
          end else begin
            s_nxt.busy  = 1'b0;
            s_nxt.done  = 1'b1;
            s_nxt.state = ST_IDLE;
          end
        end else if (s_r.timer == 4'h0) begin
          s_nxt.busy  = 1'b0;
          s_nxt.err   = 1'b1;
          s_nxt.state = ST_IDLE;
        end
      end
      ST_READ: begin
        // Entry cycle: check the descriptor and issue the read half of the update.
        if (!s_r.cmd_valid && s_r.timer == RSP_TIMEOUT) begin
          if (set_bad) begin
            s_nxt.busy  = 1'b0;
            s_nxt.err   = 1'b1;
            s_nxt.state = ST_IDLE;
          end else begin
            s_nxt.cmd_valid  = 1'b1;
            s_nxt.cmd_write  = 1'b0;
            s_nxt.cmd_opcode = f_rdop;
            s_nxt.cmd_addr   = tgt_addr;
            s_nxt.cmd_mode   = f_access ? MODE_1S1S1S : s_r.mode;
            s_nxt.cmd_dummy  = (f_access || s_r.mode == MODE_1S1S1S) ? 4'h0 : f_dummy;
            s_nxt.cmd_wdata  = 8'h00;
            s_nxt.timer      = s_r.timer - 4'h1;
          end
        end else if (lnk.rsp_valid) begin
          if (lnk.rsp_ok) begin
            s_nxt.regval = lnk.rsp_rdata;
            s_nxt.timer  = RSP_TIMEOUT;
            s_nxt.state  = ST_WRITE;
          end else begin
            s_nxt.busy  = 1'b0;
            s_nxt.err   = 1'b1;
            s_nxt.state = ST_IDLE;
          end
        end else if (s_r.timer == 4'h0) begin
          s_nxt.busy  = 1'b0;
          s_nxt.err   = 1'b1;
          s_nxt.state = ST_IDLE;
        end else begin
          s_nxt.timer = s_r.timer - 4'h1;
        end
      end
      ST_WRITE: begin
        // Entry cycle issues the write-back; the same address and mode are reused.
        if (!s_r.cmd_valid && s_r.timer == RSP_TIMEOUT) begin
          s_nxt.cmd_valid  = 1'b1;
          s_nxt.cmd_write  = 1'b1;
          s_nxt.cmd_opcode = f_wrop;
          s_nxt.cmd_wdata  = new_val;
          s_nxt.timer      = s_r.timer - 4'h1;
        end else if (lnk.rsp_valid) begin
          s_nxt.busy  = 1'b0;
          s_nxt.state = ST_IDLE;
          if (lnk.rsp_ok) begin
            s_nxt.regval = s_r.cmd_wdata;
            s_nxt.done   = 1'b1;
          end else begin
            s_nxt.err = 1'b1;
          end
        end else if (s_r.timer == 4'h0) begin
          s_nxt.busy  = 1'b0;
          s_nxt.err   = 1'b1;
          s_nxt.state = ST_IDLE;
        end else begin
          s_nxt.timer = s_r.timer - 4'h1;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Enum members are named so that no plain zero is assigned to them.
      s_r <= '{state:    ST_IDLE,
               mode:     MODE_1S1S1S,
               cmd_mode: MODE_1S1S1S,
               desc:     DESC_RST,
               regval:   REGVAL_RST,
               default:  '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  assign reg_rdata_o    = s_r.rdata;
  assign lnk.desc_req   = s_r.desc_req;
  assign lnk.cmd_valid  = s_r.cmd_valid;
  assign lnk.cmd_write  = s_r.cmd_write;
  assign lnk.cmd_opcode = s_r.cmd_opcode;
  assign lnk.cmd_addr   = s_r.cmd_addr;
  assign lnk.cmd_mode   = s_r.cmd_mode;
  assign lnk.cmd_dummy  = s_r.cmd_dummy;
  assign lnk.cmd_wdata  = s_r.cmd_wdata;

endmodule : octal_enable_host
`default_nettype wire

// [testbench/octal_enable_properties.sv]
// Purpose: Assertions on the link that joins the host end to the flash end.
// Assumes: One clock, synchronous active-high reset, signals change after a rising edge.
// Notes:   Sees the interface signals only; the bench instantiates it beside the link.
`timescale 1ns/100ps
`default_nettype none
module octal_enable_properties
  import octal_enable_pkg::*;
#(
  parameter logic [31:0] EXP_WORD = 32'h0000_0000
) (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Link signals.
  input wire logic        desc_req,
  input wire logic        desc_valid,
  input wire logic [31:0] desc_word,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [31:0] cmd_addr,
  input wire logic [2:0]  cmd_mode,
  input wire logic [3:0]  cmd_dummy,
  input wire logic [7:0]  cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic        rsp_ok,
  input wire logic [7:0]  rsp_rdata
);
  logic [7:0] rd_val_r;
  logic       flag_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Keep the last answer with rsp_ok high, read or write, so the write-back can be compared against the read before it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_val_r <= 8'h00;
    end else if (rsp_valid && rsp_ok) begin
      rd_val_r <= rsp_rdata;
    end
  end

  // A mode may only be used when its flag is set; single-line needs no flag.
  assign flag_ok = (cmd_mode == MODE_1S1S1S) || (cmd_mode == MODE_8D8D8D && desc_word[FLAG_8D]) ||
                   (cmd_mode == MODE_8S8S8S && desc_word[FLAG_8S]) ||
                   (cmd_mode == MODE_4S4D4D && desc_word[FLAG_4D]) ||
                   (cmd_mode == MODE_4S4S4S && desc_word[FLAG_4S]);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_read_ok;
    cmd_valid && !cmd_write ##1 rsp_valid && rsp_ok;
  endsequence
  sequence s_write_back;
    cmd_valid && cmd_write && (((cmd_wdata ^ rd_val_r) & ~(8'h01 << desc_word[BPOS_HI:BPOS_LO])) == 8'h00);
  endsequence

  property p_desc_answer;
    desc_req |=> desc_valid && (desc_word == EXP_WORD);
  endproperty
  property p_rsvd_zero;
    desc_valid |-> !desc_word[RSVD_BIT];
  endproperty
  property p_direct_no_addr;
    cmd_valid && !desc_word[ACCESS_BIT] |-> cmd_addr == 32'h0000_0000;
  endproperty
  property p_mode_flag;
    cmd_valid && !desc_word[ACCESS_BIT] |-> flag_ok;
  endproperty
  property p_listed_dummy;
    cmd_valid && !desc_word[ACCESS_BIT] && cmd_mode != MODE_1S1S1S |-> cmd_dummy == desc_word[DUMMY_HI:DUMMY_LO];
  endproperty
  property p_single_dummy;
    cmd_valid && cmd_mode == MODE_1S1S1S |-> cmd_dummy == 4'h0;
  endproperty
  property p_rd_op;
    cmd_valid && !cmd_write |-> cmd_opcode == desc_word[RDOP_HI:RDOP_LO] && cmd_opcode != 8'h00;
  endproperty
  property p_wr_op;
    cmd_valid && cmd_write |-> cmd_opcode == desc_word[WROP_HI:WROP_LO] && cmd_opcode != 8'h00;
  endproperty
  property p_rmw;
    s_read_ok |-> ##[1:4] s_write_back;
  endproperty

  a_desc_answer: assert property (p_desc_answer) else $error("descriptor answer wrong");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
  a_direct_no_addr: assert property (p_direct_no_addr) else $error("direct command has address");
  a_mode_flag: assert property (p_mode_flag) else $error("mode used without flag");
  a_listed_dummy: assert property (p_listed_dummy) else $error("dummy count differs");
  a_single_dummy: assert property (p_single_dummy) else $error("single-line with dummy");
  a_rd_op: assert property (p_rd_op) else $error("read opcode wrong");
  a_wr_op: assert property (p_wr_op) else $error("write opcode wrong");
  a_rmw: assert property (p_rmw) else $error("write-back alters other bits");
endmodule : octal_enable_properties
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench joining the host end and the flash end.
// Assumes: Direct access form, inverted polarity, enable bit at position five.
// Notes:   Software port driven right after rising edges; read data sampled in the next cycle.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import octal_enable_pkg::*;
  localparam logic [31:0] EXP_WORD = 32'hC5A8_0501;
  localparam logic        EXP_POL  = 1'b1;
  localparam int          EXP_BPOS = 5;

  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  flash_reg;
  logic        octal_mode;
  logic [7:0]  exp_reg   = 8'h00;
  int          fails     = 0;
  int          compares  = 0;
  int          cycles    = 0;

  ////////////////////////////////////////////////////////////////////////////
  octal_enable_if octal_enable_if_i ();
  octal_enable_dev #(.POL(EXP_POL), .BIT_POS(3'h5)) octal_enable_dev_i (.clk_i(clk), .rst_i(rst),
    .lnk(octal_enable_if_i), .flash_reg_o(flash_reg), .octal_mode_o(octal_mode));
  octal_enable_host octal_enable_host_i (.clk_i(clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .lnk(octal_enable_if_i));
  octal_enable_properties #(.EXP_WORD(EXP_WORD)) octal_enable_properties_i (.clk_i(clk), .rst_i(rst),
    .desc_req(octal_enable_if_i.desc_req), .desc_valid(octal_enable_if_i.desc_valid),
    .desc_word(octal_enable_if_i.desc_word), .cmd_valid(octal_enable_if_i.cmd_valid),
    .cmd_write(octal_enable_if_i.cmd_write), .cmd_opcode(octal_enable_if_i.cmd_opcode),
    .cmd_addr(octal_enable_if_i.cmd_addr), .cmd_mode(octal_enable_if_i.cmd_mode),
    .cmd_dummy(octal_enable_if_i.cmd_dummy), .cmd_wdata(octal_enable_if_i.cmd_wdata),
    .rsp_valid(octal_enable_if_i.rsp_valid), .rsp_ok(octal_enable_if_i.rsp_ok),
    .rsp_rdata(octal_enable_if_i.rsp_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // A 20 MHz clock, and a ceiling that catches a hung handshake.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus_rd

  // Polls with a bound; a hang counts as a mismatch.
  task automatic wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    bus_rd(OFS_STATUS, st);
    while (st[STAT_BUSY] !== 1'b0 && n < 40) begin
      bus_rd(OFS_STATUS, st);
      n++;
    end
    chk(n, 0 + (n < 40 ? n : 0));
  endtask : wait_idle

  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst     <= 1'b0;
    exp_reg = 8'h00;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Everything idle after reset; unmapped reads come back as zero.
  task automatic t_reset_vals();
    logic [31:0] d;
    bus_rd(OFS_STATUS, d);
    chk(d, 32'h0000_0000);
    bus_rd(OFS_DESC, d);
    chk(d, DESC_RST);
    bus_rd(8'h10, d);
    chk(d, 32'h0000_0000);
    // With inverted polarity a cleared register already means octal mode is on.
    chk({23'h0, octal_mode, flash_reg}, {23'h0, exp_reg[EXP_BPOS] ^ EXP_POL, exp_reg});
  endtask : t_reset_vals

  // Fetch the word and try to overwrite it from software.
  task automatic t_fetch();
    logic [31:0] d;
    bus_wr(OFS_CTRL, 32'h0000_0001);
    wait_idle(d);
    chk(d & 32'h1F, 32'h1A);
    bus_wr(OFS_DESC, 32'hFFFF_FFFF);
    bus_rd(OFS_DESC, d);
    chk(d, EXP_WORD);
    chk(d & 32'h2000_0000, 32'h0);
  endtask : t_fetch

  // Change the enable bit in one mode; refused modes leave the register alone.
  task automatic t_set(input mode_e m, input logic want, input logic ok);
    logic [31:0] st;
    bus_wr(OFS_CTRL, {25'h0, m, 1'b0, want, 2'b10});
    wait_idle(st);
    if (ok) exp_reg[EXP_BPOS] = want ^ EXP_POL;
    chk(st & 32'h1F, {27'h0, exp_reg[EXP_BPOS] ^ EXP_POL, 1'b1, !ok, ok, 1'b0});
    chk({24'h0, flash_reg}, {24'h0, exp_reg});
    chk({31'h0, octal_mode}, {31'h0, exp_reg[EXP_BPOS] ^ EXP_POL});
    // The host's copy of the register must match the flash end after every start.
    bus_rd(OFS_REGVAL, st);
    chk(st, {24'h0, exp_reg});
    bus_rd(OFS_CTRL, st);
    chk(st, {25'h0, m, 1'b0, want, 2'b00});
  endtask : t_set

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    do_reset(6);
    t_reset_vals();
    t_fetch();
    t_set(MODE_8D8D8D, 1'b1, 1'b1);
    t_set(MODE_8S8S8S, 1'b0, 1'b0);
    t_set(MODE_4S4D4D, 1'b0, 1'b1);
    t_set(MODE_4S4S4S, 1'b1, 1'b0);
    t_set(MODE_1S1S1S, 1'b1, 1'b1);
    @(posedge clk);
    do_reset(2);
    t_reset_vals();
    t_set(MODE_4S4D4D, 1'b0, 1'b1);
    finish_test();
  end
endmodule : tb
`default_nettype wire
